// [bench/eess_exit_saver_tb.sv]
// Self-checking bench for the exit state saver.
`timescale 1ns/100ps
`include "eess_defs.svh"
module eess_exit_saver_tb
   import eess_pkg::*;
   ;
   localparam logic [63:0] BASE = 64'h0001_0000; // Page aligned.
   localparam logic [63:0] GPR = BASE + 64'h1000 - 64'hB0;
   logic sys_clk = 1'b0, rst = 1'b1, slow = 1'b0, reg_wr = 1'b0;
   logic reg_rd = 1'b0, exit_req = 1'b0, entry_req = 1'b0, resume_req = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, xs_idx;
   logic [63:0] xs_word, rest_sp, rest_fp, mem_rdata;
   logic mem_ready, mem_rvalid, exit_done, exit_notify, busy;
   logic entry_done, entry_fail, resume_done, irq;
   logic [4:0] ev = 5'h00;
   eess_exc_t exit_exc = '{1'b1, 1'b0, 8'h0E};
   eess_arch_t arch;
   eess_mem_req_t mem_req;
   int bad_count = 0, n_compared = 0;
   always #2.5 sys_clk = ~sys_clk;
   // Extended-state words carry their own index so misplacement shows.
   assign xs_word = {32'hA5A5_0000, xs_idx};
   always @(posedge sys_clk)
      ev <= ev | {exit_notify, exit_done, entry_done, entry_fail, resume_done};
   eess_exit_saver u_eess_exit_saver (.sys_clk(sys_clk), .rst(rst),
      .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exit_req(exit_req),
      .exit_exc(exit_exc), .arch(arch), .xs_idx(xs_idx), .xs_word(xs_word),
      .exinfo_addr(64'h7000), .exinfo_code(64'h0E), .entry_req(entry_req),
      .entry_sp(64'h5A00), .entry_fp(64'h5B00), .resume_req(resume_req),
      .mem_req(mem_req), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .busy(busy), .exit_done(exit_done),
      .exit_notify(exit_notify), .rest_sp(rest_sp), .rest_fp(rest_fp),
      .entry_done(entry_done), .entry_fail(entry_fail),
      .resume_done(resume_done), .irq(irq));
   eess_frame_mem u_eess_frame_mem (.sys_clk(sys_clk), .slow(slow),
      .mem_req(mem_req), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata));
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_rd} <= {w, !w};
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      {reg_wr, reg_rd} <= 2'b00;
      #1;
      if (!w) chk(reg_rdata, d);
   endtask
   // Clears the event record, pulses one request and waits for an answer.
   task automatic req(input int k);
      ev = 5'h00;
      @(posedge sys_clk);
      {exit_req, entry_req, resume_req} <= 3'b100 >> k;
      @(posedge sys_clk);
      {exit_req, entry_req, resume_req} <= 3'b000;
      for (int i = 0; i < 3000 && ev[3:0] == 4'h0; i++)
         @(posedge sys_clk) #1;
      if (ev[3:0] == 4'h0)
      begin
         bad_count++;
         $display("unexpected at %0t: no answer", $time);
         complete_run;
      end
   endtask
   task automatic t_exit;
      u_eess_frame_mem.m[GPR+160] = 64'h0100_0000_0000_0000;
      req(0);
      chk(ev[4:3], 2'b11);
      chk(u_eess_frame_mem.m[BASE+8], 64'hA5A5_0000_0000_0001);
      chk(u_eess_frame_mem.m[GPR-16], 64'h7000);
      for (int i = 0; i < 16; i++)
         chk(u_eess_frame_mem.m[GPR+8*i], 64'h1000 + i);
      chk(u_eess_frame_mem.m[GPR+128], 64'h0246);
      chk(u_eess_frame_mem.m[GPR+160], 64'h0100_0000_8000_030E);
      chk(u_eess_frame_mem.m[GPR+168], 64'hF5);
      chk(u_eess_frame_mem.m[GPR+176], 64'h65);
      chk(rest_sp, 64'h5A00);
      chk(rest_fp, 64'h5B00);
      rw(0, `EESS_REG_CUR_INDEX, 32'h1);
      rw(0, `EESS_REG_IRQ_STATUS, 32'h5);
      chk(irq, 1'b1);
      rw(1, `EESS_REG_IRQ_CLEAR, 32'h5);
      rw(0, `EESS_REG_IRQ_STATUS, 32'h0);
      chk(irq, 1'b0);
      $display("exit test done");
   endtask
   task automatic t_entry;
      req(1);
      chk(ev[2] & !busy, 1'b1);
      chk(u_eess_frame_mem.m[GPR+152], 64'h5B00);
      $display("entry test done");
   endtask
   // Second frame, software exception, notify byte left clear.
   task automatic t_exit_sw;
      @(posedge sys_clk);
      exit_exc <= '{1'b1, 1'b1, 8'h03};
      req(0);
      chk(ev[4:3], 2'b01);
      chk(u_eess_frame_mem.m[GPR+64'h10A0], 64'h8000_0603);
      $display("sw exit test done");
   endtask
   task automatic t_fail_resume;
      req(1);
      chk(ev[1], 1'b1);
      req(2);
      chk(ev[0], 1'b1);
      rw(0, `EESS_REG_CUR_INDEX, 32'h1);
      $display("resume test done");
   endtask
   initial
   begin
      for (int i = 0; i < 16; i++)
         arch.gpr[i] = 64'h1000 + i;
      {arch.flags, arch.ip} = {64'h0246, 64'h4000};
      {arch.fs_segment_base, arch.gs_segment_base} = {64'hF5, 64'h65};
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rw(0, `EESS_REG_FRAME_SIZE, `EESS_RST_FRAME_SIZE);
      rw(0, `EESS_REG_AVAIL, `EESS_RST_AVAIL);
      rw(0, 8'h3C, 32'h0);
      rw(1, `EESS_REG_BASE_LO, BASE[31:0]);
      rw(1, `EESS_REG_XS_SIZE, 32'h10);
      rw(1, `EESS_REG_MISC_SEL, 32'h1);
      rw(1, `EESS_REG_MISC_ENUM, 32'h1);
      rw(1, `EESS_REG_IRQ_ENABLE, 32'h1);
      slow <= 1'b1;
      t_entry;
      t_exit;
      t_exit_sw;
      t_fail_resume;
      complete_run;
   end
endmodule // eess_exit_saver_tb

// [bench/eess_frame_mem.sv]
// Behavioural enclave memory holding the save frames.
`timescale 1ns/100ps
module eess_frame_mem
   import eess_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          slow,
   input  wire eess_mem_req_t mem_req,
   output logic               mem_ready,
   output logic               mem_rvalid,
   output logic [63:0]        mem_rdata
);
   logic [63:0] m [logic [63:0]];
   logic [63:0] w;
   logic        ph = 1'b0;
   initial mem_rdata = 64'h0;
   // Slow mode accepts on every other cycle, so held requests are exercised.
   assign mem_ready = !slow || ph;
   // Only strobed bytes change, so byte 167 outlives the report.
   always @(posedge sys_clk)
   begin
      ph <= !ph;
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata; // A released bus never looks stable.
      if (mem_req.valid && mem_ready)
      begin
         w = m.exists(mem_req.addr) ? m[mem_req.addr] : 64'h0;
         if (mem_req.we)
         begin
            for (int b = 0; b < 8; b++)
               if (mem_req.strb[b]) w[8*b+:8] = mem_req.wdata[8*b+:8];
            m[mem_req.addr] = w;
         end
         else
         begin
            mem_rvalid <= 1'b1;
            mem_rdata <= w;
         end
      end
   end
endmodule // eess_frame_mem

// [src/eess_defs.svh]
// Offsets, field positions, reset values and sizes of the exit state saver.
`ifndef EESS_DEFS_SVH
`define EESS_DEFS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define EESS_GPR_REGION_BYTES 64'd176
`define EESS_OFF_FLAGS        8'd128
`define EESS_OFF_IP           8'd136
`define EESS_OFF_OUT_SP       8'd144
`define EESS_OFF_OUT_FP       8'd152
`define EESS_OFF_REPORT       8'd160
`define EESS_OFF_FS_BASE      8'd168
`define EESS_OFF_GS_BASE      8'd176
`define EESS_LAST_SLOT        5'd22
`define EESS_MISC_COMP_BYTES  64'd16
`define EESS_REPORT_STRB      8'h7F
`define EESS_NOTIFY_BIT       0

// ----------------------------------------------------------------------
// Exit report fields
// ----------------------------------------------------------------------
`define EESS_TYPE_HW          3'h3
`define EESS_TYPE_SW          3'h6

// ----------------------------------------------------------------------
// Register map, byte offsets on the plain register port
// ----------------------------------------------------------------------
`define EESS_REG_BASE_LO      8'h00
`define EESS_REG_BASE_HI      8'h04
`define EESS_REG_FRAME_SIZE   8'h08
`define EESS_REG_AVAIL        8'h0C
`define EESS_REG_CUR_INDEX    8'h10
`define EESS_REG_XS_SIZE      8'h14
`define EESS_REG_MISC_SEL     8'h18
`define EESS_REG_MISC_ENUM    8'h1C
`define EESS_REG_IRQ_STATUS   8'h20
`define EESS_REG_IRQ_ENABLE   8'h24
`define EESS_REG_IRQ_CLEAR    8'h28

// ----------------------------------------------------------------------
// Reset values and interrupt bits
// ----------------------------------------------------------------------
`define EESS_RST_FRAME_SIZE   32'h0000_1000
`define EESS_RST_AVAIL        32'h0000_0001
`define EESS_RST_ZERO32       32'h0000_0000
`define EESS_IRQ_EXIT         0
`define EESS_IRQ_ENTRY_FAIL   1
`define EESS_IRQ_NOTIFY       2
`define EESS_IRQ_RESUME       3

`endif

// [src/eess_exit_saver.sv]
// Exit state saver: dumps thread state into the current save frame.
//
// Contract
// - An async exit writes the thread state into the frame picked by the current frame index.
// - Extended state is written from byte 0 of the frame in non-compacted form.
// - The general register region is the last 176 bytes of the frame; the code writes its gs base slot at offset 176, past the frame end.
// - The extra-information region exists only for a nonzero enumeration and sits right below the register region, sized by the highest select bit.
// - The sixteen registers go to 8-byte slots 0 to 120 in save order.
// - Flags go to offset 128 and the instruction pointer to offset 136.
// - Outside stack and frame pointers are stored at 144/152 on entry and restored from there on exit.
// - A 4-byte exit report is written at offset 160.
// - Exit notifications are delivered only when bit 0 of byte 167 is set.
// - The frame index rises on each exit and falls on each resume, except that a resume at index zero leaves it at zero.
// - An entry fails when no save frame is left.
// - The report holds vector in 7:0, type in 10:8 and valid in 31.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "eess_defs.svh"
module eess_exit_saver
   import eess_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          ce,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [31:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [31:0]   reg_rdata,
   input  wire logic          exit_req,
   input  wire eess_exc_t     exit_exc,
   input  wire eess_arch_t    arch,
   output logic      [31:0]   xs_idx,
   input  wire logic [63:0]   xs_word,
   input  wire logic [63:0]   exinfo_addr,
   input  wire logic [63:0]   exinfo_code,
   input  wire logic          entry_req,
   input  wire logic [63:0]   entry_sp,
   input  wire logic [63:0]   entry_fp,
   input  wire logic          resume_req,
   output eess_mem_req_t      mem_req,
   input  wire logic          mem_ready,
   input  wire logic          mem_rvalid,
   input  wire logic [63:0]   mem_rdata,
   output logic               busy,
   output logic               exit_done,
   output logic               exit_notify,
   output logic [63:0]        rest_sp,
   output logic [63:0]        rest_fp,
   output logic               entry_done,
   output logic               entry_fail,
   output logic               resume_done,
   output logic               irq
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Base byte address of frame idx; frames are assumed page aligned.
   function automatic logic [63:0] frame_addr(input logic [63:0] base,
                                              input logic [31:0] idx,
                                              input logic [31:0] size);
      frame_addr = base + (64'(idx) * 64'(size));
   endfunction

   // Index of the highest set bit, zero for an empty mask.
   function automatic logic [5:0] top_bit(input logic [31:0] m);
      top_bit = 6'h0;
      for (int i = 0; i < 32; i++)
      begin
         if (m[i])
         begin
            top_bit = 6'(i);
         end
      end
   endfunction

   // Byte size of the extra-information region.
   function automatic logic [63:0] misc_bytes(input logic [31:0] en,
                                              input logic [31:0] sel);
      if (en == 32'h0 || sel == 32'h0)
      begin
         misc_bytes = 64'h0;
      end
      else
      begin
         misc_bytes = (64'(top_bit(sel)) + 64'h1) * `EESS_MISC_COMP_BYTES;
      end
   endfunction

   eess_st_t    r;
   eess_st_t    n;
   logic [63:0] slot_data;
   logic [7:0]  slot_strb;
   logic        mem_free;
   logic [31:0] misc_words;
   logic [4:0]  comp;

   // ----------------------------------------------------------------------
   // Slot source for the general register region
   // ----------------------------------------------------------------------
   eess_slot_src u_slot (
      .arch   (arch),
      .report (r.report),
      .slot   (r.cnt[4:0]),
      .data   (slot_data),
      .strb   (slot_strb)
   );

   // A request may be replaced once nothing is pending or it was taken.
   assign mem_free   = !r.mreq.valid || mem_ready;
   assign misc_words = 32'(misc_bytes(r.misc_enum, r.misc_sel) >> 3);
   assign comp       = r.cnt[5:1];

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   // Hardware events override software clears in the same cycle, so an
   // interrupt cause is never lost to a racing clear.
   always_comb
   begin
      logic [3:0] ev;
      logic [3:0] clr;
      ev  = 4'h0;
      clr = 4'h0;
      n   = r;
      n.exit_done   = 1'b0;
      n.entry_done  = 1'b0;
      n.entry_fail  = 1'b0;
      n.resume_done = 1'b0;
      n.notify      = 1'b0;
      n.rdata       = 32'h0;
      if (mem_free)
      begin
         n.mreq.valid = 1'b0;
      end

      // Register port: writes steer configuration, reads answer next cycle.
      if (reg_wr)
      begin
         unique case (reg_addr)
            `EESS_REG_BASE_LO:    n.ssa_base[31:0]  = reg_wdata;
            `EESS_REG_BASE_HI:    n.ssa_base[63:32] = reg_wdata;
            `EESS_REG_FRAME_SIZE: n.fsize           = reg_wdata;
            `EESS_REG_AVAIL:      n.avail           = reg_wdata;
            `EESS_REG_CUR_INDEX:  n.cur_idx         = reg_wdata;
            `EESS_REG_XS_SIZE:    n.xs_size         = reg_wdata;
            `EESS_REG_MISC_SEL:   n.misc_sel        = reg_wdata;
            `EESS_REG_MISC_ENUM:  n.misc_enum       = reg_wdata;
            `EESS_REG_IRQ_ENABLE: n.irq_en          = reg_wdata[3:0];
            `EESS_REG_IRQ_CLEAR:  clr               = reg_wdata[3:0];
            default:              n.rdata           = 32'h0;
         endcase
      end
      if (reg_rd)
      begin
         unique case (reg_addr)
            `EESS_REG_BASE_LO:    n.rdata = r.ssa_base[31:0];
            `EESS_REG_BASE_HI:    n.rdata = r.ssa_base[63:32];
            `EESS_REG_FRAME_SIZE: n.rdata = r.fsize;
            `EESS_REG_AVAIL:      n.rdata = r.avail;
            `EESS_REG_CUR_INDEX:  n.rdata = r.cur_idx;
            `EESS_REG_XS_SIZE:    n.rdata = r.xs_size;
            `EESS_REG_MISC_SEL:   n.rdata = r.misc_sel;
            `EESS_REG_MISC_ENUM:  n.rdata = r.misc_enum;
            `EESS_REG_IRQ_STATUS: n.rdata = {28'h0, r.irq_st};
            `EESS_REG_IRQ_ENABLE: n.rdata = {28'h0, r.irq_en};
            default:              n.rdata = 32'h0;
         endcase
      end

      unique case (r.st)
         // Exit beats entry beats resume when they arrive together.
         ST_IDLE:
         begin
            n.cnt  = 32'h0;
            n.pend = 1'b0;
            if (exit_req)
            begin
               n.base = frame_addr(r.ssa_base, r.cur_idx, r.fsize);
               n.gpr  = frame_addr(r.ssa_base, r.cur_idx, r.fsize)
                        + 64'(r.fsize) - `EESS_GPR_REGION_BYTES;
               // Unreported exceptions leave vector and type cleared.
               n.report = exit_exc.valid ?
                  {1'b1, 20'h0,
                   exit_exc.sw_type ? `EESS_TYPE_SW : `EESS_TYPE_HW,
                   exit_exc.vector} : 32'h0;
               n.st = ST_EXTENDED_STATE_REGION;
            end
            else if (entry_req)
            begin
               if (r.cur_idx >= r.avail)
               begin
                  n.entry_fail = 1'b1;
                  ev[`EESS_IRQ_ENTRY_FAIL] = 1'b1;
               end
               else
               begin
                  n.gpr = frame_addr(r.ssa_base, r.cur_idx, r.fsize)
                          + 64'(r.fsize) - `EESS_GPR_REGION_BYTES;
                  n.osp = entry_sp;
                  n.ofp = entry_fp;
                  n.st  = ST_ENTRY;
               end
            end
            else if (resume_req)
            begin
               if (r.cur_idx != 32'h0)
               begin
                  n.cur_idx = r.cur_idx - 32'h1;
               end
               n.resume_done = 1'b1;
               ev[`EESS_IRQ_RESUME] = 1'b1;
            end
         end
         // Extended state words, one per 8 bytes, from frame byte 0.
         ST_EXTENDED_STATE_REGION:
         begin
            if (mem_free)
            begin
               if (r.cnt < (r.xs_size >> 3))
               begin
                  n.mreq = '{1'b1, 1'b1, r.base + 64'({r.cnt, 3'h0}),
                             xs_word, 8'hFF};
                  n.cnt  = r.cnt + 32'h1;
               end
               else
               begin
                  n.cnt = 32'h0;
                  n.st  = ST_MISC;
               end
            end
         end
         // Component i fills the 16 bytes at gpr - 16*(i+1); only the
         // selected ones are stored, the others are skipped untouched.
         ST_MISC:
         begin
            if (mem_free)
            begin
               if (r.cnt < misc_words)
               begin
                  if (r.misc_sel[comp])
                  begin
                     n.mreq = '{1'b1, 1'b1,
                        r.gpr - (64'(comp) + 64'h1) * `EESS_MISC_COMP_BYTES
                        + 64'({r.cnt[0], 3'h0}),
                        (comp == 5'h0) ?
                           (r.cnt[0] ? exinfo_code : exinfo_addr) : 64'h0,
                        8'hFF};
                  end
                  n.cnt = r.cnt + 32'h1;
               end
               else
               begin
                  n.cnt = 32'h0;
                  n.st  = ST_GPR;
               end
            end
         end
         // Register region; the outside pointer slots are left alone
         // because they are read back below.
         ST_GPR:
         begin
            if (mem_free)
            begin
               if (r.cnt[4:0] > `EESS_LAST_SLOT)
               begin
                  n.cnt = 32'h0;
                  n.st  = ST_READ;
               end
               else
               begin
                  if (slot_strb != 8'h00)
                  begin
                     n.mreq = '{1'b1, 1'b1,
                        r.gpr + 64'({r.cnt[4:0], 3'h0}),
                        slot_data, slot_strb};
                  end
                  n.cnt = r.cnt + 32'h1;
               end
            end
         end
         // Read back outside stack, outside frame, then the notify byte.
         ST_READ:
         begin
            if (!r.mreq.valid && !r.pend)
            begin
               n.mreq = '{1'b1, 1'b0,
                  r.gpr + ((r.cnt == 32'h0) ? 64'(`EESS_OFF_OUT_SP) :
                           (r.cnt == 32'h1) ? 64'(`EESS_OFF_OUT_FP) :
                                              64'(`EESS_OFF_REPORT)),
                  64'h0, 8'h00};
            end
            else if (r.mreq.valid && mem_ready)
            begin
               n.pend = 1'b1;
            end
            else if (r.pend && mem_rvalid)
            begin
               n.pend = 1'b0;
               n.cnt  = r.cnt + 32'h1;
               if (r.cnt == 32'h0)
               begin
                  n.rest_sp = mem_rdata;
               end
               else if (r.cnt == 32'h1)
               begin
                  n.rest_fp = mem_rdata;
               end
               else
               begin
                  n.note = mem_rdata[63:56];
                  n.st   = ST_FIN;
               end
            end
         end
         // The notify byte is read from the frame just filled, before
         // the index moves on to the next one.
         ST_FIN:
         begin
            n.cur_idx   = r.cur_idx + 32'h1;
            n.exit_done = 1'b1;
            n.notify    = r.note[`EESS_NOTIFY_BIT];
            ev[`EESS_IRQ_EXIT]   = 1'b1;
            ev[`EESS_IRQ_NOTIFY] = r.note[`EESS_NOTIFY_BIT];
            n.st = ST_IDLE;
         end
         // Entry stores the outside pointers in the current frame.
         ST_ENTRY:
         begin
            if (mem_free)
            begin
               if (r.cnt == 32'h0)
               begin
                  n.mreq = '{1'b1, 1'b1, r.gpr + 64'(`EESS_OFF_OUT_SP),
                             r.osp, 8'hFF};
                  n.cnt  = 32'h1;
               end
               else if (r.cnt == 32'h1)
               begin
                  n.mreq = '{1'b1, 1'b1, r.gpr + 64'(`EESS_OFF_OUT_FP),
                             r.ofp, 8'hFF};
                  n.cnt  = 32'h2;
               end
               else
               begin
                  n.entry_done = 1'b1;
                  n.st = ST_IDLE;
               end
            end
         end
      endcase

      n.irq_st = (r.irq_st & ~clr) | ev;
      n.irq    = |(n.irq_st & n.irq_en);
      n.busy   = (n.st != ST_IDLE);
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Clock enable low freezes everything but reset, pulses included.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         r          <= '0;
         r.st       <= ST_IDLE;
         r.fsize    <= `EESS_RST_FRAME_SIZE;
         r.avail    <= `EESS_RST_AVAIL;
         r.cur_idx  <= `EESS_RST_ZERO32;
      end
      else if (ce)
      begin
         r <= n;
      end
   end

   assign reg_rdata   = r.rdata;
   assign xs_idx      = r.cnt;
   assign mem_req     = r.mreq;
   assign busy        = r.busy;
   assign exit_done   = r.exit_done;
   assign exit_notify = r.notify;
   assign rest_sp     = r.rest_sp;
   assign rest_fp     = r.rest_fp;
   assign entry_done  = r.entry_done;
   assign entry_fail  = r.entry_fail;
   assign resume_done = r.resume_done;
   assign irq         = r.irq;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || !ce);

   held_request_a: assert property (
      r.mreq.valid && !mem_ready |=> r.mreq.valid && $stable(r.mreq.addr))
      else $error("memory request dropped before it was taken");
   extended_state_region_bounds_a: assert property (
      r.mreq.valid && r.mreq.we && r.st == ST_EXTENDED_STATE_REGION && !$past(r.st == ST_IDLE)
      |-> r.mreq.addr >= r.base && r.mreq.addr < r.base + 64'(r.xs_size))
      else $error("extended state word outside its region");
   gpr_base_a: assert property (
      r.st == ST_GPR |-> r.gpr == r.base + 64'(r.fsize) - 64'd176)
      else $error("register region not at frame end minus 176");
   misc_bounds_a: assert property (
      r.mreq.valid && r.st == ST_MISC |-> r.mreq.addr < r.gpr &&
      r.mreq.addr >= r.gpr - misc_bytes(r.misc_enum, r.misc_sel))
      else $error("extra information word outside its region");
   ptr_slots_a: assert property (
      r.mreq.valid && r.mreq.we && r.st == ST_GPR |->
      r.mreq.addr != r.gpr + 64'd144 && r.mreq.addr != r.gpr + 64'd152)
      else $error("exit overwrote an outside pointer slot");
   report_slot_a: assert property (
      r.mreq.valid && r.mreq.we && r.st == ST_GPR &&
      r.mreq.addr == r.gpr + 64'd160 |->
      r.mreq.strb == 8'h7F && r.mreq.wdata[55:32] == 24'h0)
      else $error("report slot touched the notify byte or reserved bytes");
   notify_gate_a: assert property (
      exit_notify |-> exit_done && r.note[0])
      else $error("notification without its enable bit");
   exit_inc_a: assert property (
      $rose(r.exit_done) |-> r.cur_idx == $past(r.cur_idx) + 32'h1)
      else $error("frame index did not rise on exit");
   entry_fail_a: assert property (
      $rose(r.entry_fail) |-> $past(r.cur_idx) >= $past(r.avail))
      else $error("entry refused with a frame still free");
   report_fmt_a: assert property (
      r.st == ST_EXTENDED_STATE_REGION && $past(r.st == ST_IDLE) |->
      r.report[30:11] == 20'h0 && (r.report[31] || r.report == 32'h0))
      else $error("exit report reserved bits set");

endmodule // eess_exit_saver

// [src/eess_pkg.sv]
// Types shared by the exit state saver and its slot source.
package eess_pkg;

   // ----------------------------------------------------------------------
   // Architectural state offered by the core
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [15:0][63:0] gpr;
      logic [63:0]       flags;
      logic [63:0]       ip;
      logic [63:0]       fs_segment_base;
      logic [63:0]       gs_segment_base;
   } eess_arch_t;

   typedef struct packed {
      logic        valid;
      logic        sw_type;
      logic [7:0]  vector;
   } eess_exc_t;

   typedef struct packed {
      logic        valid;
      logic        we;
      logic [63:0] addr;
      logic [63:0] wdata;
      logic [7:0]  strb;
   } eess_mem_req_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_EXTENDED_STATE_REGION, ST_MISC, ST_GPR, ST_READ, ST_FIN, ST_ENTRY
   } eess_state_t;

   typedef struct packed {
      eess_state_t   st;
      logic [31:0]   cnt;
      logic          pend;
      logic [63:0]   base;
      logic [63:0]   gpr;
      logic [31:0]   report;
      logic [63:0]   osp;
      logic [63:0]   ofp;
      logic [7:0]    note;
      eess_mem_req_t mreq;
      logic [31:0]   cur_idx;
      logic [63:0]   ssa_base;
      logic [31:0]   fsize;
      logic [31:0]   avail;
      logic [31:0]   xs_size;
      logic [31:0]   misc_sel;
      logic [31:0]   misc_enum;
      logic [3:0]    irq_en;
      logic [3:0]    irq_st;
      logic          irq;
      logic [31:0]   rdata;
      logic          exit_done;
      logic          entry_done;
      logic          entry_fail;
      logic          resume_done;
      logic          notify;
      logic [63:0]   rest_sp;
      logic [63:0]   rest_fp;
      logic          busy;
   } eess_st_t;

endpackage

// [src/eess_slot_src.sv]
// Data and byte strobes for each 8-byte slot of the general register region.
`timescale 1ns/100ps
`include "eess_defs.svh"
module eess_slot_src
   import eess_pkg::*;
(
   input  wire eess_arch_t  arch,
   input  wire logic [31:0] report,
   input  wire logic [4:0]  slot,
   output logic      [63:0] data,
   output logic      [7:0]  strb
);

   // ----------------------------------------------------------------------
   // Slot selection
   // ----------------------------------------------------------------------
   // Slots 0..15 hold the sixteen registers in save order.
   // The report slot keeps byte 7 unwritten so the notify enable that
   // software owns survives every exit.
   always_comb
   begin
      data = 64'h0;
      strb = 8'hFF;
      if (slot < 5'd16)
      begin
         data = arch.gpr[slot[3:0]];
      end
      else if (slot == 5'(`EESS_OFF_FLAGS >> 3))
      begin
         data = arch.flags;
      end
      else if (slot == 5'(`EESS_OFF_IP >> 3))
      begin
         data = arch.ip;
      end
      else if (slot == 5'(`EESS_OFF_REPORT >> 3))
      begin
         data = {32'h0, report};
         strb = `EESS_REPORT_STRB;
      end
      else if (slot == 5'(`EESS_OFF_FS_BASE >> 3))
      begin
         data = arch.fs_segment_base;
      end
      else if (slot == 5'(`EESS_OFF_GS_BASE >> 3))
      begin
         data = arch.gs_segment_base;
      end
      else
      begin
         strb = 8'h00;
      end
   end

endmodule // eess_slot_src
